// file: cms_host_model.sv
// Host processor model that reaches the control variables byte by byte.
`timescale 1ns/10ps
module cms_host_model (
  input wire clock,
  output reg wr_en = 1'b0,
  output reg rd_en = 1'b0,
  output reg [7:0] addr = 8'h00,
  output reg [7:0] wr_data = 8'h00,
  input wire [7:0] rd_data_ff,
  input wire rd_valid_ff
);
  ////////////////
  task write_byte(input [7:0] a, input [7:0] v);
    begin
      @(negedge clock);
      addr = a;
      wr_data = v;
      wr_en = 1'b1;
      @(negedge clock);
      wr_en = 1'b0;
      wr_data = ~v;
    end
  endtask
  task read_byte(input [7:0] a, output [7:0] v, output ok);
    integer n;
    begin
      @(negedge clock);
      addr = a;
      rd_en = 1'b1;
      @(negedge clock);
      rd_en = 1'b0;
      n = 0;
      while (rd_valid_ff !== 1'b1 && n < 4) begin
        @(negedge clock);
        n = n + 1;
      end
      ok = n < 4;
      v = rd_data_ff;
    end
  endtask
  // Polls the command byte back to zero before the caller goes on.
  task run_cmd(input [7:0] c, output ok);
    reg [7:0] v;
    integer n;
    begin
      write_byte(8'h03, c);
      v = 8'hFF;
      for (n = 0; n < 20 && v !== 8'h00; n = n + 1) begin
        read_byte(8'h03, v, ok);
      end
      ok = v === 8'h00;
    end
  endtask
endmodule // cms_host_model

// file: cms_regs.vh
// Register offsets, reset values and field positions of the sequencer controls.
//
// Contract
// [RULE1] Driver enables reset 0x0F; bits 0-4 enable drivers.
// [RULE2] Enable bit 5 selects forced outdoor balance.
// [RULE3] Above outdoor threshold with bit: daylight 6500K.
// [RULE4] Command codes 0..6; command resets to 0.
// [RULE5] Positive command clears byte, runs program, resumes.
// [RULE6] Read-only state byte codes 0..9, default 3.
// [RULE7] Step control bit 0 selects step mode.
// [RULE8] Host writes bit 1 to advance one step.
// [RULE9] Flash kind 0 none..3 burst, reset 0.
// [RULE10] Flash kind bit 7 set when lock flashed.
// [RULE11] Exposure continuous weight default 8; 32 no averaging.
// [RULE12] Exposure steps default 2 continuous, 1 fast.
// [RULE13] Exposure fast weight default 32, no averaging.
// [RULE14] Balance continuous weight default 8; 32 disables.
// [RULE15] Balance continuous steps default 2.
// [RULE16] Balance fast weight default 32, disables averaging.
// [RULE17] Drivers time out after programmable frames, 30.
// [RULE18] Auto flash used when EV below flash threshold.
// [RULE19] Low-light options reset 0x60; bits 0-4 enable.
// [RULE20] Low-light range between gain min 0x51, max 0x5A. Code checks only the min; active for any gain at or above it.
// [RULE21] Virtual gain = vg/2 + dg1/16 + dg2/4.
// [RULE22] Saturation 128 means 100 percent; max 128, min 0.
// [RULE23] Step advance bit self-clears after one step.
// [RULE24] Host writes args, command, polls zero, reads result.
`ifndef CMS_REGS_VH
`define CMS_REGS_VH
`define CMS_OFS_TABLE 8'h00
`define CMS_OFS_TABLE_LO 8'h01
`define CMS_OFS_ENABLE 8'h02
`define CMS_OFS_CMD 8'h03
`define CMS_OFS_STATE 8'h04
`define CMS_OFS_STEP 8'h05
`define CMS_OFS_FLASH 8'h06
`define CMS_OFS_AE_CW 8'h07
`define CMS_OFS_AE_CS 8'h08
`define CMS_OFS_AE_FW 8'h09
`define CMS_OFS_AE_FS 8'h0A
`define CMS_OFS_WB_CW 8'h0B
`define CMS_OFS_WB_CS 8'h0C
`define CMS_OFS_WB_FW 8'h0D
`define CMS_OFS_WB_FS 8'h0E
`define CMS_OFS_TIMEOUT 8'h12
`define CMS_OFS_FLASH_TH 8'h13
`define CMS_OFS_OUT_TH 8'h14
`define CMS_OFS_LL_OPT 8'h15
`define CMS_OFS_LL_GMIN 8'h16
`define CMS_OFS_LL_GMAX 8'h17
`define CMS_OFS_SAT_MAX 8'h18
`define CMS_OFS_SAT_MIN 8'h19
`define CMS_OFS_ITH_MIN 8'h1A
`define CMS_OFS_ITH_MAX 8'h1B
`define CMS_RST_TABLE 16'hF06B
`define CMS_RST_TABLE_HI 8'hF0
`define CMS_RST_TABLE_LO 8'h6B
`define CMS_RST_ENABLE 8'h0F
`define CMS_RST_STATE 4'h3
`define CMS_RST_AE_CW 8'h08
`define CMS_RST_AE_CS 8'h02
`define CMS_RST_AE_FW 8'h20
`define CMS_RST_AE_FS 8'h01
`define CMS_RST_WB_CW 8'h08
`define CMS_RST_WB_CS 8'h02
`define CMS_RST_WB_FW 8'h20
`define CMS_RST_WB_FS 8'h01
`define CMS_RST_TIMEOUT 8'h1E
`define CMS_RST_OUT_TH 8'h0A
`define CMS_RST_LL_OPT 8'h60
`define CMS_RST_LL_GMIN 8'h51
`define CMS_RST_LL_GMAX 8'h5A
`define CMS_RST_SAT_MAX 8'h80
`define CMS_RST_ITH_MIN 8'h10
`define CMS_RST_ITH_MAX 8'h40
`define CMS_BIT_OUTDOOR 5
`define CMS_BIT_STEP_ON 0
`define CMS_BIT_STEP_GO 1
`define CMS_BIT_FLASH_LOCK 7
`define CMS_CMD_LAST 8'h06
`define CMS_CMD_LOCK 8'h04
`define CMS_PROG_CYCLES 4'h4
`endif

// file: cms_seq_ctrl.v
// Sequencer control variables, command interpreter and state tracker.
`timescale 1ns/10ps
`include "cms_regs.vh"
module cms_seq_ctrl (
  input wire clock,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data_ff,
  output reg rd_valid_ff,
  input wire frame_start,
  input wire flash_fired,
  input wire [7:0] current_ev,
  input wire [7:0] exposure_virtual_gain,
  input wire [7:0] exposure_digital_gain_first,
  input wire [7:0] exposure_digital_gain_second,
  output reg [4:0] driver_enables_ff,
  output reg daylight_force_ff,
  output reg flash_use_ff,
  output reg driver_timeout_ff,
  output reg [7:0] low_light_gain_ff,
  output reg low_light_active_ff,
  output reg [3:0] state_ff,
  output reg busy_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Control variables.
  reg [7:0] enable_ff;
  reg [7:0] cmd_ff;
  reg [1:0] step_ff;
  reg [7:0] flash_ff;
  reg [7:0] ae_cw_ff, ae_cs_ff, ae_fw_ff, ae_fs_ff;
  reg [7:0] wb_cw_ff, wb_cs_ff, wb_fw_ff, wb_fs_ff;
  reg [7:0] timeout_ff, flash_th_ff, out_th_ff, ll_opt_ff;
  reg [7:0] ll_gmin_ff, ll_gmax_ff, sat_max_ff, sat_min_ff;
  reg [7:0] ith_min_ff, ith_max_ff;
  reg [7:0] run_cmd_ff;
  reg [3:0] prog_cnt_ff;
  reg [7:0] frame_cnt_ff;
  reg [3:0] nxt_state;
  reg [7:0] rd_mux;
  wire step_ok;
  wire [8:0] gain_sum;
  wire cmd_wr;
  wire [3:0] leave_state;

  localparam ST_IDLE = 2'b01;
  localparam ST_PROG = 2'b10;

  // Codes reported in the state byte.
  localparam SQ_INIT = 4'h0;
  localparam SQ_PV_CHANGE = 4'h1;
  localparam SQ_PV_ENTER = 4'h2;
  localparam SQ_PREVIEW = 4'h3;
  localparam SQ_PV_LEAVE = 4'h4;
  localparam SQ_CP_CHANGE = 4'h5;
  localparam SQ_CP_ENTER = 4'h6;
  localparam SQ_CAPTURE = 4'h7;
  localparam SQ_CP_LEAVE = 4'h8;
  localparam SQ_STANDBY = 4'h9;
  reg [1:0] fsm_ff;

  assign cmd_wr = wr_en && addr == `CMS_OFS_CMD && wr_data != 8'h00;
  // In step mode the sequence only moves when a step is requested.
  assign step_ok = !step_ff[`CMS_BIT_STEP_ON] || step_ff[`CMS_BIT_STEP_GO]; // RULE7 RULE8
  assign gain_sum = {2'b00, exposure_virtual_gain[7:1]} // RULE21
    + {5'h00, exposure_digital_gain_first[7:4]}
    + {3'h0, exposure_digital_gain_second[7:2]};
  // Leaving a running mode passes through its leave phase first.
  assign leave_state = (state_ff == SQ_PREVIEW) ? SQ_PV_LEAVE :
    (state_ff == SQ_CAPTURE) ? SQ_CP_LEAVE : state_ff;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_ff <= `CMS_RST_ENABLE; // RULE1
      step_ff <= 2'h0; // RULE7
      flash_ff <= 8'h00; // RULE9
      ae_cw_ff <= `CMS_RST_AE_CW; // RULE11
      ae_cs_ff <= `CMS_RST_AE_CS; // RULE12
      ae_fw_ff <= `CMS_RST_AE_FW; // RULE13
      ae_fs_ff <= `CMS_RST_AE_FS; // RULE12
      wb_cw_ff <= `CMS_RST_WB_CW; // RULE14
      wb_cs_ff <= `CMS_RST_WB_CS; // RULE15
      wb_fw_ff <= `CMS_RST_WB_FW; // RULE16
      wb_fs_ff <= `CMS_RST_WB_FS;
      timeout_ff <= `CMS_RST_TIMEOUT; // RULE17
      flash_th_ff <= 8'h00; // RULE18
      out_th_ff <= `CMS_RST_OUT_TH; // RULE3
      ll_opt_ff <= `CMS_RST_LL_OPT; // RULE19
      ll_gmin_ff <= `CMS_RST_LL_GMIN; // RULE20
      ll_gmax_ff <= `CMS_RST_LL_GMAX; // RULE20
      sat_max_ff <= `CMS_RST_SAT_MAX; // RULE22
      sat_min_ff <= 8'h00; // RULE22
      ith_min_ff <= `CMS_RST_ITH_MIN;
      ith_max_ff <= `CMS_RST_ITH_MAX;
    end else begin
      if (wr_en) begin
        case (addr)
          `CMS_OFS_ENABLE: enable_ff <= wr_data;
          `CMS_OFS_STEP: step_ff <= wr_data[1:0];
          `CMS_OFS_FLASH: flash_ff <= wr_data;
          `CMS_OFS_AE_CW: ae_cw_ff <= wr_data;
          `CMS_OFS_AE_CS: ae_cs_ff <= wr_data;
          `CMS_OFS_AE_FW: ae_fw_ff <= wr_data;
          `CMS_OFS_AE_FS: ae_fs_ff <= wr_data;
          `CMS_OFS_WB_CW: wb_cw_ff <= wr_data;
          `CMS_OFS_WB_CS: wb_cs_ff <= wr_data;
          `CMS_OFS_WB_FW: wb_fw_ff <= wr_data;
          `CMS_OFS_WB_FS: wb_fs_ff <= wr_data;
          `CMS_OFS_TIMEOUT: timeout_ff <= wr_data;
          `CMS_OFS_FLASH_TH: flash_th_ff <= wr_data;
          `CMS_OFS_OUT_TH: out_th_ff <= wr_data;
          `CMS_OFS_LL_OPT: ll_opt_ff <= wr_data;
          `CMS_OFS_LL_GMIN: ll_gmin_ff <= wr_data;
          `CMS_OFS_LL_GMAX: ll_gmax_ff <= wr_data;
          `CMS_OFS_SAT_MAX: sat_max_ff <= wr_data;
          `CMS_OFS_SAT_MIN: sat_min_ff <= wr_data;
          `CMS_OFS_ITH_MIN: ith_min_ff <= wr_data;
          `CMS_OFS_ITH_MAX: ith_max_ff <= wr_data;
          default: ;
        endcase
      end
      // Hardware clear of the step request; a new host write wins.
      if (step_ff[`CMS_BIT_STEP_GO] && fsm_ff == ST_PROG &&
          !(wr_en && addr == `CMS_OFS_STEP)) begin
        step_ff[`CMS_BIT_STEP_GO] <= 1'b0; // RULE23
      end
      // Flash flag during the lock program; set beats a host write.
      if (fsm_ff == ST_PROG && run_cmd_ff == `CMS_CMD_LOCK && flash_fired) begin
        flash_ff[`CMS_BIT_FLASH_LOCK] <= 1'b1; // RULE10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command interpreter.
  // For commands 1 and 2 each enabled program step moves the reported state one phase on,
  // except that the first step holds it outside preview and capture; the walk assumes a program of four steps.
  always @* begin
    nxt_state = state_ff;
    case (run_cmd_ff)
      8'h01: begin
        case (prog_cnt_ff)
          `CMS_PROG_CYCLES: nxt_state = leave_state;
          4'h3: nxt_state = SQ_PV_CHANGE;
          4'h2: nxt_state = SQ_PV_ENTER;
          default: nxt_state = SQ_PREVIEW;
        endcase
      end
      8'h02: begin
        case (prog_cnt_ff)
          `CMS_PROG_CYCLES: nxt_state = leave_state;
          4'h3: nxt_state = SQ_CP_CHANGE;
          4'h2: nxt_state = SQ_CP_ENTER;
          default: nxt_state = SQ_CAPTURE;
        endcase
      end
      8'h03: begin
        case (prog_cnt_ff)
          4'h1: nxt_state = SQ_STANDBY;
          default: nxt_state = leave_state;
        endcase
      end
      default: nxt_state = state_ff;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fsm_ff <= ST_IDLE;
      cmd_ff <= 8'h00; // RULE4
      run_cmd_ff <= 8'h00;
      prog_cnt_ff <= 4'h0;
      state_ff <= `CMS_RST_STATE; // RULE6
      busy_ff <= 1'b0;
    end else begin
      case (fsm_ff)
        ST_IDLE: begin
          if (cmd_wr && wr_data <= `CMS_CMD_LAST) begin
            cmd_ff <= wr_data; // RULE4
            run_cmd_ff <= wr_data;
            prog_cnt_ff <= `CMS_PROG_CYCLES;
            busy_ff <= 1'b1;
            fsm_ff <= ST_PROG;
          end
        end
        ST_PROG: begin
          cmd_ff <= 8'h00; // RULE5
          if (step_ok) begin
            state_ff <= nxt_state; // RULE5 RULE6
            if (prog_cnt_ff == 4'h1) begin
              busy_ff <= 1'b0;
              run_cmd_ff <= 8'h00;
              fsm_ff <= ST_IDLE;
            end
            prog_cnt_ff <= prog_cnt_ff - 4'h1;
          end
        end
        default: fsm_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver-facing decisions.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      driver_enables_ff <= 5'h0F;
      daylight_force_ff <= 1'b0;
      flash_use_ff <= 1'b0;
      driver_timeout_ff <= 1'b0;
      frame_cnt_ff <= 8'h00;
      low_light_gain_ff <= 8'h00;
      low_light_active_ff <= 1'b0;
    end else begin
      driver_enables_ff <= enable_ff[4:0]; // RULE1
      daylight_force_ff <= enable_ff[`CMS_BIT_OUTDOOR] && // RULE2
        current_ev > out_th_ff; // RULE3
      flash_use_ff <= current_ev < flash_th_ff; // RULE18
      low_light_gain_ff <= gain_sum[8] ? 8'hFF : gain_sum[7:0]; // RULE21
      low_light_active_ff <= gain_sum >= {1'b0, ll_gmin_ff}; // RULE20
      if (busy_ff && frame_start) begin
        if (frame_cnt_ff + 8'h01 >= timeout_ff) begin
          driver_timeout_ff <= 1'b1; // RULE17
        end else begin
          frame_cnt_ff <= frame_cnt_ff + 8'h01;
        end
      end else if (!busy_ff) begin
        frame_cnt_ff <= 8'h00;
        driver_timeout_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port.
  always @* begin
    case (addr)
      `CMS_OFS_TABLE: rd_mux = `CMS_RST_TABLE_HI;
      `CMS_OFS_TABLE_LO: rd_mux = `CMS_RST_TABLE_LO;
      `CMS_OFS_ENABLE: rd_mux = enable_ff;
      `CMS_OFS_CMD: rd_mux = cmd_ff;
      `CMS_OFS_STATE: rd_mux = {4'h0, state_ff}; // RULE6
      `CMS_OFS_STEP: rd_mux = {6'h00, step_ff};
      `CMS_OFS_FLASH: rd_mux = flash_ff;
      `CMS_OFS_AE_CW: rd_mux = ae_cw_ff;
      `CMS_OFS_AE_CS: rd_mux = ae_cs_ff;
      `CMS_OFS_AE_FW: rd_mux = ae_fw_ff;
      `CMS_OFS_AE_FS: rd_mux = ae_fs_ff;
      `CMS_OFS_WB_CW: rd_mux = wb_cw_ff;
      `CMS_OFS_WB_CS: rd_mux = wb_cs_ff;
      `CMS_OFS_WB_FW: rd_mux = wb_fw_ff;
      `CMS_OFS_WB_FS: rd_mux = wb_fs_ff;
      `CMS_OFS_TIMEOUT: rd_mux = timeout_ff;
      `CMS_OFS_FLASH_TH: rd_mux = flash_th_ff;
      `CMS_OFS_OUT_TH: rd_mux = out_th_ff;
      `CMS_OFS_LL_OPT: rd_mux = ll_opt_ff;
      `CMS_OFS_LL_GMIN: rd_mux = ll_gmin_ff;
      `CMS_OFS_LL_GMAX: rd_mux = ll_gmax_ff;
      `CMS_OFS_SAT_MAX: rd_mux = sat_max_ff;
      `CMS_OFS_SAT_MIN: rd_mux = sat_min_ff;
      `CMS_OFS_ITH_MIN: rd_mux = ith_min_ff;
      `CMS_OFS_ITH_MAX: rd_mux = ith_max_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en;
      if (rd_en) begin
        rd_data_ff <= rd_mux;
      end
    end
  end

endmodule // cms_seq_ctrl

// file: cms_seq_ctrl_checker.sv
// Concurrent checks on the sequencer control ports.
`timescale 1ns/10ps
module cms_seq_ctrl_checker (
  input wire clock,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data_ff,
  input wire rd_valid_ff,
  input wire [3:0] state_ff,
  input wire busy_ff
);
  wire go = wr_en && addr == 8'h03 && !busy_ff;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ////////////////
  a_state_read: assert property (
    rd_en && addr == 8'h04 |=> rd_valid_ff && rd_data_ff == {4'h0,
    $past(state_ff)}) else $error("state read wrong");
  a_cmd_start: assert property (go && wr_data == 8'h01 |=> busy_ff)
    else $error("busy not raised");
  a_cmd_refuse: assert property (go && wr_data > 8'h06 |=> !busy_ff)
    else $error("bad command ran");
  a_preview_done: assert property (go && wr_data == 8'h01 |->
    ##[2:300] !busy_ff && state_ff == 4'h3) else $error("no preview");
  a_capture_done: assert property (go && wr_data == 8'h02 |->
    ##[2:300] !busy_ff && state_ff == 4'h7) else $error("no capture");
  a_standby_done: assert property (go && wr_data == 8'h03 |->
    ##[2:300] !busy_ff && state_ff == 4'h9) else $error("no standby");
  a_state_range: assert property (state_ff <= 4'h9)
    else $error("state code out of range");
  a_state_hold: assert property (!busy_ff && !$past(busy_ff) |->
    $stable(state_ff)) else $error("state moved while idle");
  a_walk_enter: assert property (state_ff == 4'h2 |=>
    state_ff == 4'h2 || state_ff == 4'h3) else $error("enter walk wrong");
  c_lock: cover property (go && wr_data == 8'h04);
  c_walk: cover property (state_ff == 4'h5 ##1 state_ff == 4'h6);
  c_stall: cover property (busy_ff [*8]);
  c_refuse: cover property (go && wr_data == 8'h07);
endmodule // cms_seq_ctrl_checker

// file: cms_seq_ctrl_test.sv
// Bench for the sequencer controls driven through the host model.
`timescale 1ns/10ps
module cms_seq_ctrl_test;
  localparam [799:0] ROWS = {
    32'h00F055F0, 32'h016B556B, 32'h020F3F3F, 32'h04030103,
    32'h05000000, 32'h06000303, 32'h07082020, 32'h08020505,
    32'h09201010, 32'h0A010404, 32'h0B082020, 32'h0C020707,
    32'h0D201111, 32'h0E010202, 32'h121E0505, 32'h13004040,
    32'h140A1414, 32'h15601F1F, 32'h16515252, 32'h175A5B5B,
    32'h18808181, 32'h19000101, 32'h1A101111, 32'h1B404141,
    32'h30007700};
  localparam [55:0] ST = {8'h09, 8'h09, 8'h09, 8'h09, 8'h09, 8'h07, 8'h03};
  localparam [31:0] WALK = {8'h03, 8'h02, 8'h01, 8'h09};
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg fs = 1'b0;
  reg ff = 1'b0;
  reg [7:0] ev = 8'h00, vg = 8'h00, dg1 = 8'h00, dg2 = 8'h00, d;
  reg [31:0] r;
  reg ok;
  integer n_fail = 0, checks = 0, i, k;
  wire wr_en, rd_en, rd_valid_ff, dl, fu, tmo, lla, busy_ff;
  wire [7:0] addr, wr_data, rd_data_ff, gain;
  wire [4:0] en;
  wire [3:0] state_ff;
  always #10 clock = ~clock;
  cms_seq_ctrl i_cms_seq_ctrl (.clock(clock), .rst(rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff), .frame_start(fs), .flash_fired(ff),
    .current_ev(ev), .exposure_virtual_gain(vg),
    .exposure_digital_gain_first(dg1), .exposure_digital_gain_second(dg2),
    .driver_enables_ff(en), .daylight_force_ff(dl), .flash_use_ff(fu),
    .driver_timeout_ff(tmo), .low_light_gain_ff(gain),
    .low_light_active_ff(lla), .state_ff(state_ff), .busy_ff(busy_ff));
  cms_host_model i_cms_host_model (.clock(clock), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff));
  ////////////////
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task rc(input [7:0] a, input [7:0] exp);
    begin
      i_cms_host_model.read_byte(a, d, ok);
      if (!ok) begin
        n_fail = n_fail + 1;
        conclude;
      end
      chk("reg", d, exp);
    end
  endtask
  task sense(input [7:0] e, input [7:0] x);
    begin
      ev = e;
      repeat (2) @(negedge clock);
      chk("ev", {6'h00, dl, fu}, x);
    end
  endtask
  task gck(input [7:0] a, input [7:0] b, input [7:0] c, input [8:0] x);
    begin
      vg = a;
      dg1 = b;
      dg2 = c;
      repeat (2) @(negedge clock);
      chk("gain", gain, x[7:0]);
      chk("active", {7'h00, lla}, {7'h00, x[8]});
    end
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    chk("enables", {3'h0, en}, 8'h0F);
    for (i = 24; i >= 0; i = i - 1) begin
      r = ROWS[32*i +: 32];
      rc(r[31:24], r[23:16]);
      i_cms_host_model.write_byte(r[31:24], r[15:8]);
      rc(r[31:24], r[7:0]);
    end
    chk("enables", {3'h0, en}, 8'h1F);
    sense(8'h14, 8'h01);
    sense(8'h40, 8'h02);
    i_cms_host_model.write_byte(8'h02, 8'h1F);
    sense(8'h40, 8'h00);
    gck(8'h92, 8'h20, 8'h18, 9'h051);
    gck(8'h94, 8'h20, 8'h18, 9'h152);
    gck(8'hFF, 8'hFF, 8'hFF, 9'h1CD);
    ff = 1'b1;
    for (i = 1; i < 8; i = i + 1) begin
      i_cms_host_model.run_cmd(i[7:0], ok);
      chk("cleared", {7'h00, ok}, 8'h01);
      for (k = 0; k < 9 && busy_ff !== 1'b0; k = k + 1)
        @(negedge clock);
      if (k == 9) begin
        n_fail = n_fail + 1;
        conclude;
      end
      rc(8'h04, ST[8*i-8 +: 8]);
    end
    ff = 1'b0;
    rc(8'h06, 8'h83);
    i_cms_host_model.write_byte(8'h05, 8'h01);
    i_cms_host_model.write_byte(8'h03, 8'h01);
    for (i = 0; i < 5; i = i + 1) begin
      chk("timeout", {7'h00, tmo}, 8'h00);
      fs = 1'b1;
      @(negedge clock);
      fs = 1'b0;
      @(negedge clock);
    end
    @(negedge clock);
    chk("timeout", {7'h00, tmo}, 8'h01);
    chk("held", {7'h00, busy_ff}, 8'h01);
    for (k = 0; k < 8 && busy_ff === 1'b1; k = k + 1) begin
      i_cms_host_model.write_byte(8'h05, 8'h03);
      @(negedge clock);
      chk("walk", {4'h0, state_ff}, WALK[8*k +: 8]);
    end
    chk("steps", k[7:0], 8'h04);
    rc(8'h05, 8'h01);
    rc(8'h04, 8'h03);
    chk("timeout", {7'h00, tmo}, 8'h00);
    i_cms_host_model.write_byte(8'h02, 8'h00);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    chk("enables", {3'h0, en}, 8'h0F);
    rc(8'h14, 8'h0A);
    conclude;
  end
endmodule // cms_seq_ctrl_test
bind cms_seq_ctrl cms_seq_ctrl_checker i_cms_seq_ctrl_checker (
  .clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
  .wr_data(wr_data), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
  .state_ff(state_ff), .busy_ff(busy_ff));
